//--- arfc_cal_seq.v
// calibration sequencer: power-on and on-command calibration
// assumes request and power-down inputs are synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "arfc_consts.vh"
module arfc_cal_seq #(
  parameter LOW_CYC = `ARFC_CAL_LOW_CYC,
  parameter HIGH_CYC = `ARFC_CAL_HIGH_CYC,
  parameter RUN_CYC = `ARFC_CAL_RUN_CYC,
  parameter DLY_CYC = `ARFC_PWR_DLY_CYC,
  parameter CW = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // controls
  input wire cal_req,
  input wire pwrdn_req,
  // status
  output wire cal_running,
  output wire cal_done,
  output wire powered_down
);
  // =====================================
  // states
  localparam ST_INIT = 3'd0;
  localparam ST_DLY = 3'd1;
  localparam ST_IDLE = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_PWRDN = 3'd4;
  localparam [CW-1:0] LOW_N = LOW_CYC[CW-1:0];
  localparam [CW-1:0] HIGH_N = HIGH_CYC[CW-1:0];
  localparam [CW-1:0] RUN_N = RUN_CYC[CW-1:0];
  localparam [CW-1:0] DLY_N = DLY_CYC[CW-1:0];

  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg [CW-1:0] lo_r;
  reg [CW-1:0] lo_nxt;
  reg [CW-1:0] hi_r;
  reg [CW-1:0] hi_nxt;
  reg armed_r;
  reg armed_nxt;
  reg skip_r;
  reg skip_nxt;
  reg done_r;
  reg done_nxt;
  wire cmd_go;

  // =====================================
  // request qualification
  // low then high counters filter noise on the request pin
  assign cmd_go = armed_r && (hi_r == HIGH_N); // R11

  always @* begin
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    armed_nxt = armed_r;
    if (st_r == ST_PWRDN) begin
      lo_nxt = {CW{1'b0}}; // R14
      hi_nxt = {CW{1'b0}};
      armed_nxt = 1'b0;
    end else if (!cal_req) begin
      hi_nxt = {CW{1'b0}};
      if (lo_r != LOW_N) begin
        lo_nxt = lo_r + {{(CW-1){1'b0}}, 1'b1};
      end else begin
        armed_nxt = 1'b1; // R11
      end
    end else begin
      lo_nxt = {CW{1'b0}};
      if (!armed_r) begin
        hi_nxt = {CW{1'b0}};
      end else if (hi_r != HIGH_N) begin
        hi_nxt = hi_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
    if (cmd_go && st_r == ST_IDLE) begin
      armed_nxt = 1'b0;
      hi_nxt = {CW{1'b0}};
    end
  end

  // =====================================
  // sequencer
  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    skip_nxt = skip_r;
    done_nxt = 1'b0;
    case (st_r)
      ST_INIT: begin
        // strap sampled after release, never under reset
        skip_nxt = cal_req; // R12
        cnt_nxt = {CW{1'b0}};
        st_nxt = ST_DLY;
      end
      ST_DLY: begin
        // delay counter held while powered down at power-up
        if (!pwrdn_req) begin
          cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
        if (skip_r) begin
          st_nxt = ST_IDLE; // R12
        end else if (cnt_r == DLY_N && !pwrdn_req) begin
          // power-down on the last delay cycle still holds the start off
          cnt_nxt = {CW{1'b0}};
          st_nxt = ST_RUN; // R05 R06
        end
      end
      ST_IDLE: begin
        if (pwrdn_req) begin
          st_nxt = ST_PWRDN;
        end else if (cmd_go) begin
          cnt_nxt = {CW{1'b0}};
          st_nxt = ST_RUN; // R05 R11
        end
      end
      ST_RUN: begin
        // power-down waits for the sequence to end
        cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
        if (cnt_r == RUN_N - {{(CW-1){1'b0}}, 1'b1}) begin
          done_nxt = 1'b1;
          st_nxt = pwrdn_req ? ST_PWRDN : ST_IDLE; // R13
        end
      end
      ST_PWRDN: begin
        if (!pwrdn_req) begin
          st_nxt = ST_IDLE; // R14
        end
      end
      default: begin
        st_nxt = ST_INIT;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_INIT;
      cnt_r <= {CW{1'b0}};
      lo_r <= {CW{1'b0}};
      hi_r <= {CW{1'b0}};
      armed_r <= 1'b0;
      skip_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      armed_r <= armed_nxt;
      skip_r <= skip_nxt;
      done_r <= done_nxt;
    end
  end

  assign cal_running = (st_r == ST_RUN); // R07
  assign cal_done = done_r;
  assign powered_down = (st_r == ST_PWRDN);
endmodule // arfc_cal_seq
`default_nettype wire

//--- arfc_consts.vh
// constants for the range flag and calibration control block
// assumes inclusion by arfc_top.v and arfc_cal_seq.v
`ifndef ARFC_CONSTS_VH
`define ARFC_CONSTS_VH
// calibration request, run length and power-up delay timing, in sample clock cycles
`define ARFC_CAL_LOW_CYC 80
`define ARFC_CAL_HIGH_CYC 80
`define ARFC_CAL_RUN_CYC 1400
`define ARFC_PWR_DLY_CYC 64
// code span limits
`define ARFC_CODE_MIN 8'h00
`define ARFC_CODE_MAX 8'hFF
// full-scale range select
`define ARFC_RANGE_NORMAL 1'b1
`define ARFC_RANGE_REDUCED 1'b0
`define ARFC_FSADJ_RST 8'h80
// register byte offsets
`define ARFC_A_CTRL 12'h000
`define ARFC_A_FSADJ 12'h004
`define ARFC_A_STAT 12'h008
`define ARFC_A_ISTAT 12'h00C
`define ARFC_A_IEN 12'h010
`define ARFC_A_ICLR 12'h014
`endif

//--- arfc_top.v
// range flag and calibration control top with apb register file
// assumes all pins synchronous to pclk; host keeps pins steady during calibration
//
// Function
// R01 - a clipped conversion drives the flag positive output high and negative output low.
// R02 - the flag stays active while either bus result would fall outside 00h to FFh.
// R03 - in normal mode the select pin picks normal range when high, reduced when low.
// R04 - in extended control mode the range comes from the full-scale adjust register.
// R05 - calibration runs after power-up and again on each host request.
// R06 - the calibration sequence is the same whenever the sample clock starts.
// R07 - the running output is high for the whole calibration and low otherwise.
// R08 - the host keeps the sample clock stable and only toggles serial clock in enhanced mode.
// R09 - the host leaves output level, edge, data sense and data rate alone during calibration.
// R10 - the host leaves mode enables, resync, chip select, power-down and request alone then.
// R11 - a request is low for the low count then high for the high count, then calibration starts.
// R12 - a request pin high at power-up skips power-on calibration until a proper request.
// R13 - power-down raised during calibration waits until the sequence ends.
// R14 - while powered down the request input is ignored.
`timescale 1ns/10ps
`default_nettype none
`include "arfc_consts.vh"
module arfc_top #(
  parameter RUN_CYC = `ARFC_CAL_RUN_CYC,
  parameter DLY_CYC = `ARFC_PWR_DLY_CYC
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // converter results, true value with two extra bits of headroom
  input wire [9:0] result_a,
  input wire [9:0] result_b,
  // control pins
  input wire full_scale_select,
  input wire cal_req_pin,
  input wire power_down_pin,
  // flag and status pins
  output reg range_flag_p,
  output reg range_flag_n,
  output wire calibration_running,
  output reg range_sel_normal,
  output reg [7:0] range_adjust,
  // interrupt
  output wire irq
);
  // =====================================
  // register map
  localparam [11:0] A_CTRL = `ARFC_A_CTRL;
  localparam [11:0] A_FSADJ = `ARFC_A_FSADJ;
  localparam [11:0] A_STAT = `ARFC_A_STAT;
  localparam [11:0] A_ISTAT = `ARFC_A_ISTAT;
  localparam [11:0] A_IEN = `ARFC_A_IEN;
  localparam [11:0] A_ICLR = `ARFC_A_ICLR;

  reg ext_ctrl_r;
  reg [7:0] fsadj_r;
  reg [2:0] ist_r;
  reg [2:0] ien_r;
  reg run_d_r;
  wire cal_done;
  wire pwrdn_state;
  wire out_a;
  wire out_b;
  wire wr_en;
  wire [2:0] ev;
  wire [2:0] clr;

  // =====================================
  // calibration sequencer
  arfc_cal_seq #(
    .RUN_CYC(RUN_CYC),
    .DLY_CYC(DLY_CYC)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .cal_req(cal_req_pin),
    .pwrdn_req(power_down_pin),
    .cal_running(calibration_running),
    .cal_done(cal_done),
    .powered_down(pwrdn_state)
  );

  // =====================================
  // out of range flag
  function oor;
    input [9:0] v;
    begin
      oor = (v[9:8] != 2'b00);
    end
  endfunction

  assign out_a = oor(result_a);
  assign out_b = oor(result_b);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_flag_p <= 1'b0;
      range_flag_n <= 1'b1;
    end else begin
      range_flag_p <= out_a | out_b; // R01 R02
      range_flag_n <= ~(out_a | out_b); // R01 R02
    end
  end

  // =====================================
  // full-scale range
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_sel_normal <= `ARFC_RANGE_NORMAL;
      range_adjust <= `ARFC_FSADJ_RST;
    end else if (ext_ctrl_r) begin
      range_sel_normal <= `ARFC_RANGE_NORMAL;
      range_adjust <= fsadj_r; // R04
    end else begin
      range_sel_normal <= full_scale_select; // R03
      range_adjust <= `ARFC_FSADJ_RST;
    end
  end

  // =====================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  // events: calibration start, calibration done, out of range on either result (level, every cycle)
  assign ev = {out_a | out_b, cal_done, calibration_running & ~run_d_r};
  assign clr = (wr_en && paddr == A_ICLR) ? pwdata[2:0] : 3'h0;
  assign irq = |(ist_r & ien_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ctrl_r <= 1'b0;
      fsadj_r <= `ARFC_FSADJ_RST;
      ist_r <= 3'h0;
      ien_r <= 3'h0;
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= calibration_running;
      // set wins over a clear in the same cycle
      ist_r <= (ist_r & ~clr) | ev;
      // mode changes are host's duty to avoid during calibration
      if (wr_en && paddr == A_CTRL) begin
        ext_ctrl_r <= pwdata[0]; // R10
      end else if (wr_en && paddr == A_FSADJ) begin
        fsadj_r <= pwdata[7:0];
      end else if (wr_en && paddr == A_IEN) begin
        ien_r <= pwdata[2:0];
      end
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    if (paddr == A_CTRL) begin
      prdata = {31'h0, ext_ctrl_r};
    end else if (paddr == A_FSADJ) begin
      prdata = {24'h0, fsadj_r};
    end else if (paddr == A_STAT) begin
      prdata = {28'h0, pwrdn_state, range_flag_p, range_sel_normal, calibration_running};
    end else if (paddr == A_ISTAT) begin
      prdata = {29'h0, ist_r};
    end else if (paddr == A_IEN) begin
      prdata = {29'h0, ien_r};
    end
  end
endmodule // arfc_top
`default_nettype wire

//--- arfc_sva.sv
// port checker for arfc_top
// assumes bind onto arfc_top, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module arfc_sva #(parameter RUN_CYC = 20) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // pins
  input wire [9:0] result_a,
  input wire [9:0] result_b,
  input wire full_scale_select,
  input wire cal_req_pin,
  input wire power_down_pin,
  input wire range_flag_p,
  input wire range_flag_n,
  input wire calibration_running,
  input wire range_sel_normal,
  input wire [7:0] range_adjust
);
  // ====
  // shadow state
  logic ext_r;
  logic [7:0] adj_r;
  logic [7:0] hi_r;
  int run_r;
  wire wr = psel && penable && pwrite;
  wire oor = |{result_a[9:8], result_b[9:8]};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_r <= 1'b0;
      adj_r <= 8'h80;
      hi_r <= 8'h00;
      run_r <= 0;
    end else begin
      if (wr && paddr == 12'h000) ext_r <= pwdata[0];
      if (wr && paddr == 12'h004) adj_r <= pwdata[7:0];
      // saturate so a long high strap never wraps into a fake count
      hi_r <= !cal_req_pin ? 8'h00 : hi_r + {7'h00, hi_r != 8'hFF};
      run_r <= calibration_running ? run_r + 1 : 0;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_run_end; $fell(calibration_running); endsequence
  sequence s_cmd_ok; hi_r >= 8'h51 && hi_r <= 8'h53; endsequence
  chk_flag_set: assert property (oor |=> range_flag_p && !range_flag_n)
    else $error("flag not raised");
  chk_flag_clr: assert property (!oor |=> !range_flag_p && range_flag_n)
    else $error("flag not cleared");
  chk_range_pin: assert property ($past(presetn) && !ext_r && !$past(ext_r) |->
    range_sel_normal == $past(full_scale_select) && range_adjust == 8'h80)
    else $error("pin range wrong");
  chk_range_ext: assert property ($past(presetn) && ext_r && $past(ext_r) && $stable(adj_r) |->
    range_sel_normal && range_adjust == adj_r) else $error("register range wrong");
  chk_run_len: assert property (s_run_end |-> run_r == RUN_CYC)
    else $error("run length wrong");
  chk_run_hold: assert property (calibration_running && run_r < RUN_CYC - 1 |=>
    calibration_running) else $error("run ended early");
  chk_pd_ignore: assert property (power_down_pin && !calibration_running |=>
    !calibration_running) else $error("run began in power down");
  chk_cmd_start: assert property ($rose(calibration_running) && $past(cal_req_pin) |->
    s_cmd_ok) else $error("run began off count");
endmodule // arfc_sva
bind arfc_top arfc_sva #(.RUN_CYC(RUN_CYC)) u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .result_a(result_a),
  .result_b(result_b),
  .full_scale_select(full_scale_select),
  .cal_req_pin(cal_req_pin),
  .power_down_pin(power_down_pin),
  .range_flag_p(range_flag_p),
  .range_flag_n(range_flag_n),
  .calibration_running(calibration_running),
  .range_sel_normal(range_sel_normal),
  .range_adjust(range_adjust)
);
`default_nettype wire

//--- arfc_host.sv
// host model driving the calibration request pin
// assumes start pulses only while idle and outside calibration
`timescale 1ns/10ps
`default_nettype none
module arfc_host (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // command
  input wire strap,
  input wire start,
  input wire [7:0] lo_len,
  input wire [7:0] hi_len,
  // pin
  output logic cal_req_pin,
  output logic busy
);
  logic [8:0] cnt_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_req_pin <= strap;
      busy <= 1'b0;
      cnt_r <= 9'h000;
    // level, edge and rate pins are not driven here, so they never move mid-run
    end else if (start) begin
      busy <= 1'b1;
      cal_req_pin <= 1'b0;
      cnt_r <= 9'h001;
    end else if (busy) begin
      cnt_r <= cnt_r + 9'h001;
      // drops back low after the high phase, never raised mid-run
      cal_req_pin <= cnt_r >= lo_len && cnt_r < lo_len + hi_len;
      busy <= cnt_r < lo_len + hi_len;
    end
  end
endmodule // arfc_host
`default_nettype wire

//--- adc_range_flag_and_calibration_control_test.sv
// self-checking bench for arfc_top
// assumes arfc_top, arfc_host and arfc_sva compiled first
`timescale 1ns/10ps
`default_nettype none
module adc_range_flag_and_calibration_control_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] res_a = 10'h000;
  logic [9:0] res_b = 10'h000;
  logic fss = 1'b1;
  logic pwrdn = 1'b0;
  logic strap = 1'b0;
  logic start = 1'b0;
  logic [7:0] lo_len = 8'h5A;
  logic [7:0] hi_len = 8'h55;
  logic [31:0] rd;
  logic [31:0] d;
  wire pready, pslverr, irq, req, fp, fn, run, rsn;
  wire [31:0] prdata;
  wire [7:0] radj;
  int fail_count = 0;
  int check_count = 0;
  int n;
  int k;
  always #2.5 pclk = ~pclk;
  arfc_top #(.RUN_CYC(20), .DLY_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .result_a(res_a), .result_b(res_b),
    .full_scale_select(fss), .cal_req_pin(req), .power_down_pin(pwrdn), .range_flag_p(fp),
    .range_flag_n(fn), .calibration_running(run), .range_sel_normal(rsn),
    .range_adjust(radj), .irq);
  arfc_host host (.pclk, .presetn, .strap, .start, .lo_len, .hi_len,
    .cal_req_pin(req), .busy());
  // ====
  // tasks
  function automatic logic [1:0] flag_exp(input logic [9:0] a, input logic [9:0] b);
    return (|{a[9:8], b[9:8]}) ? 2'b10 : 2'b01;
  endfunction
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      // pready and prdata still show their pre-edge values here
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    cmp(pslverr, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so back-to-back calls never drive psel twice in a step
    @(posedge pclk);
  endtask
  task automatic wait_run(input logic lvl, input int lim);
    n = 0;
    @(negedge pclk);
    while (run !== lvl && n < lim) begin
      @(negedge pclk);
      n++;
    end
    if (run !== lvl) begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask
  // counts cycles with the running output high over a fixed window
  task automatic watch_run(input int c);
    n = 0;
    repeat (c) begin
      @(negedge pclk);
      if (run !== 1'b0) n++;
    end
    @(posedge pclk);
  endtask
  task automatic pulse();
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
  endtask
  // ====
  // sequence
  initial begin
    void'($urandom(32'h5AEF6EF8));
    tick(3);
    presetn <= 1'b1;
    wait_run(1'b1, 40);
    cmp(n < 40, 1);
    wait_run(1'b0, 60);
    cmp(n + 1, 20);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd[1:0], 2'h3);
    apb(1'b0, 12'h008, 32'h0);
    cmp(rd, 32'h2);
    for (k = 0; k < 40; k++) begin
      res_a <= (k < 4) ? 10'h0FF + k[9:0] : 10'($urandom);
      res_b <= 10'($urandom_range(0, 300));
      tick(2);
      cmp(flag_exp(res_a, res_b), {fp, fn});
    end
    for (k = 0; k < 6; k++) begin
      fss <= (k < 2) ? k[0] : 1'($urandom);
      tick(3);
      cmp({rsn, radj}, {fss, 8'h80});
    end
    d = $urandom & 32'hFF;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h004, d);
    tick(1);
    cmp({rsn, radj}, {1'b1, d[7:0]});
    apb(1'b0, 12'h004, 32'h0);
    cmp(rd, d);
    apb(1'b0, 12'h020, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    res_a <= 10'h000;
    res_b <= 10'h000;
    apb(1'b1, 12'h014, 32'h7);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 12'h010, k ? 32'h0 : 32'h4);
      cmp(irq, 0);
      res_a <= 10'h300;
      tick(2);
      res_a <= 10'h010;
      tick(2);
      cmp(irq, !k);
      apb(1'b1, 12'h014, 32'h4);
      cmp(irq, 0);
    end
    hi_len <= 8'h28;
    pulse();
    watch_run(200);
    cmp(n, 0);
    hi_len <= 8'h55;
    pulse();
    wait_run(1'b1, 300);
    cmp(run, 1);
    pwrdn <= 1'b1;
    wait_run(1'b0, 60);
    cmp(n + 1, 20);
    apb(1'b0, 12'h008, 32'h0);
    cmp(rd, {28'h0, 1'b1, 1'b0, fss, 1'b0});
    pulse();
    watch_run(250);
    cmp(n, 0);
    pwrdn <= 1'b0;
    strap <= 1'b1;
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    watch_run(100);
    cmp(n, 0);
    pulse();
    wait_run(1'b1, 300);
    cmp(run, 1);
    wait_run(1'b0, 60);
    cmp(n + 1, 20);
    tally_and_finish();
  end
endmodule // adc_range_flag_and_calibration_control_test
`default_nettype wire
